// ### design/dmarq_top.sv
/*
 * DMA request/acknowledge interface: request synchronising and fixed
 * priority, bus hold handshake, encoded acknowledge, end-of-process in
 * and out, shared channel 4 / interrupt 9 pin, AXI4-Lite registers and a
 * buffer-termination log FIFO.
 * Assumes the bus master releases the bus before granting, and all pins
 * are synchronous to aclk except those routed through dmarq_sync.
 */
// Added by the designer: the AXI4-Lite register port and the address map.
`timescale 1ns/1ns
`default_nettype none

module dmarq_top
   import dmarq_pkg::*;
(
   // Clock and reset
   input  wire logic              aclk,
   input  wire logic              aresetn,
   // AXI4-Lite write
   input  wire logic [ADDR_W-1:0] s_axi_awaddr,
   input  wire logic              s_axi_awvalid,
   output var  logic              s_axi_awready,
   input  wire logic [31:0]       s_axi_wdata,
   input  wire logic [3:0]        s_axi_wstrb,
   input  wire logic              s_axi_wvalid,
   output var  logic              s_axi_wready,
   output var  logic [1:0]        s_axi_bresp,
   output var  logic              s_axi_bvalid,
   input  wire logic              s_axi_bready,
   // AXI4-Lite read
   input  wire logic [ADDR_W-1:0] s_axi_araddr,
   input  wire logic              s_axi_arvalid,
   output var  logic              s_axi_arready,
   output var  logic [31:0]       s_axi_rdata,
   output var  logic [1:0]        s_axi_rresp,
   output var  logic              s_axi_rvalid,
   input  wire logic              s_axi_rready,
   // Peripheral requests, channels 0-3 then 5-7
   input  wire logic [6:0]        channel_service_request,
   input  wire logic              shared_chan4_irq_pin,
   // End of process, open-drain style
   input  wire logic              end_of_process_line_in_n,
   output var  logic              end_of_process_line_out_n,
   output var  logic              end_of_process_line_oe_n,
   // Acknowledge and bus hold
   output var  logic [2:0]        encoded_channel_ack,
   output var  logic              hold_request,
   input  wire logic              bus_grant_ack,
   // Interrupt 9 request towards the interrupt controller
   output var  logic              shared_interrupt_input
);

   dmarq_ctrl_type   ctrl;
   logic [7:0]       dma_mask;
   logic [7:0]       swreq;
   logic [7:0]       next_valid;
   logic [7:0]       done;
   logic             irq_pend;
   logic             shared_prev;
   logic [8:0]       sync_q;
   logic [7:0]       req_sync;
   logic             eop_n_used;
   logic [CNT_W-1:0] count_q [NUM_CH];
   logic [CNT_W-1:0] base_q  [NUM_CH];
   logic [7:0]       armed;
   logic [7:0]       eligible;
   logic [7:0]       eligible_after;
   logic [2:0]       winner;
   dmarq_state_type  state;
   dmarq_state_type  next_state;
   logic [2:0]       cur_ch;
   logic [2:0]       next_ch;
   logic             tc_hit;
   logic             next_tc;
   logic             ext_term;
   logic [1:0]       acc_cnt;
   logic             acc_last;
   logic             dec_ev;
   logic             term_ev;
   logic             room;
   logic             entering_req;
   logic             log_ready;
   logic             log_valid;
   logic             log_pop;
   dmarq_log_type    log_in;
   dmarq_log_type    log_out;
   logic [4:0]       log_level;
   logic             aw_got;
   logic             w_got;
   logic [ADDR_W-1:0] wr_addr;
   logic [31:0]      wr_data;
   logic [3:0]       wr_strb;
   logic             wr_en;
   logic             wr_map;
   logic             rd_map;
   logic [31:0]      rd_val;

   // Requests, end-of-process and shared pin share one synchroniser
   dmarq_sync #(
      .WIDTH     (9),
      .RESET_VAL (9'h180)
   ) u_sync (
      .aclk    (aclk),
      .aresetn (aresetn),
      .d       ({end_of_process_line_in_n, shared_chan4_irq_pin, channel_service_request}),
      .q       (sync_q)
   );

   // Open pin floats high and so requests on channel 4
   assign req_sync   = {sync_q[6:4], sync_q[7], sync_q[3:0]};
   assign eop_n_used = ctrl.eop_async ? sync_q[8] : end_of_process_line_in_n;

   // Arbitration
   always_comb begin
      eligible = ((req_sync & ~dma_mask) | swreq) & armed;
      eligible_after = eligible;
      if (term_ev) begin
         eligible_after[cur_ch] = 1'b0;
      end
      winner = 3'h0;
      for (int i = NUM_CH - 1; i >= 0; i--) begin
         if (eligible_after[i]) begin
            winner = 3'(i);
         end
      end
   end

   // Sequencing
   assign acc_last = (acc_cnt == 2'(ACCESS_CYC - 1));
   assign dec_ev   = (state == ST_REQ) && acc_last;
   assign term_ev  = (state == ST_TGT) && acc_last && (tc_hit || ext_term);
   assign room     = term_ev ? (log_level < 5'(LOG_DEPTH - 1)) : log_ready;

   always_comb begin
      next_state   = state;
      entering_req = 1'b0;
      unique case (state)
         ST_IDLE: begin
            if ((|eligible) && log_ready && !bus_grant_ack) begin
               next_state = ST_HOLD;
            end
         end
         ST_HOLD: begin
            if (bus_grant_ack) begin
               if ((|eligible) && log_ready) begin
                  next_state   = ST_REQ;
                  entering_req = 1'b1;
               end else begin
                  next_state = ST_IDLE;
               end
            end
         end
         ST_REQ: begin
            if (acc_last) begin
               next_state = ST_TGT;
            end
         end
         ST_TGT: begin
            if (acc_last) begin
               if ((|eligible_after) && room) begin
                  next_state   = ST_REQ;
                  entering_req = 1'b1;
               end else begin
                  next_state = ST_IDLE;
               end
            end
         end
      endcase
      next_ch = entering_req ? winner : cur_ch;
      next_tc = entering_req ? (count_q[winner] <= 16'h0001) : tc_hit;
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         state   <= ST_IDLE;
         acc_cnt <= 2'h0;
         cur_ch  <= 3'h0;
         tc_hit  <= 1'b0;
      end else begin
         state   <= next_state;
         acc_cnt <= (next_state != state || acc_last) ? 2'h0 : acc_cnt + 2'h1;
         cur_ch  <= next_ch;
         tc_hit  <= next_tc;
      end
   end

   // External termination is only looked at while the line is not ours
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         ext_term <= 1'b0;
      end else if (entering_req) begin
         ext_term <= 1'b0;
      end else if ((state == ST_REQ || state == ST_TGT) && end_of_process_line_oe_n
                   && !eop_n_used) begin
         ext_term <= 1'b1;
      end
   end

   // Pin outputs, all registered from the next state
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         hold_request              <= 1'b0;
         encoded_channel_ack       <= ACK_IDLE;
         end_of_process_line_out_n <= 1'b1;
         end_of_process_line_oe_n  <= 1'b1;
      end else begin
         hold_request <= (next_state != ST_IDLE);
         if (next_state == ST_REQ && next_ch != ACK_IDLE) begin
            encoded_channel_ack <= next_ch;
         end else begin
            encoded_channel_ack <= ACK_IDLE;
         end
         end_of_process_line_out_n <= !(next_state == ST_REQ && next_tc);
         end_of_process_line_oe_n  <= !(next_state == ST_REQ && next_tc);
      end
   end

   // Per-channel counts; a write arms the channel with a fresh buffer
   for (genvar ch = 0; ch < NUM_CH; ch++) begin : g_chan
      logic wr_cnt;
      assign wr_cnt = wr_en && wr_addr[7:5] == COUNT_PAGE && wr_addr[4:2] == 3'(ch);
      always_ff @(posedge aclk) begin
         if (!aresetn) begin
            count_q[ch] <= '0;
            base_q[ch]  <= '0;
            armed[ch]   <= 1'b0;
         end else if (wr_cnt) begin
            base_q[ch]  <= CNT_W'(dmarq_merge({16'h0, base_q[ch]}, wr_data, wr_strb));
            count_q[ch] <= CNT_W'(dmarq_merge({16'h0, base_q[ch]}, wr_data, wr_strb));
            armed[ch]   <= 1'b1;
         end else if (dec_ev && cur_ch == 3'(ch)) begin
            count_q[ch] <= count_q[ch] - 16'h0001;
         end else if (term_ev && cur_ch == 3'(ch)) begin
            if (next_valid[ch]) begin
               count_q[ch] <= base_q[ch];
            end else begin
               armed[ch] <= 1'b0;
            end
         end
      end
   end

   // Termination log; a full log holds off new accesses
   assign log_in = '{spare: 3'h0, external: ext_term && !tc_hit,
                     reloaded: next_valid[cur_ch], chan: cur_ch};

   dmarq_fifo #(
      .WIDTH (LOG_W),
      .DEPTH (LOG_DEPTH)
   ) u_log (
      .aclk    (aclk),
      .aresetn (aresetn),
      .s_valid (term_ev),
      .s_ready (log_ready),
      .s_data  (log_in),
      .m_valid (log_valid),
      .m_ready (log_pop),
      .m_data  (log_out),
      .level   (log_level)
   );

   // Interrupt 9 path, active low on the pin
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         shared_prev            <= 1'b1;
         irq_pend               <= 1'b0;
         shared_interrupt_input <= 1'b0;
      end else begin
         shared_prev <= sync_q[7];
         // Set wins over a same-cycle clear
         irq_pend <= (irq_pend && !(wr_en && wr_addr == ADDR_EVENT
                      && wr_strb[1] && wr_data[EVENT_IRQ_PEND]))
                     || (shared_prev && !sync_q[7]);
         shared_interrupt_input <= !ctrl.irq_mask
                                   && (ctrl.irq_edge ? irq_pend : !sync_q[7]);
      end
   end

   // Software registers
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         ctrl       <= CTRL_RESET;
         dma_mask   <= DMA_MASK_RESET;  // Channel 4 pin may float active
         swreq      <= 8'h00;
         next_valid <= 8'h00;
         done       <= 8'h00;
      end else begin
         if (wr_en && wr_addr == ADDR_CTRL && wr_strb[0]) begin
            ctrl <= wr_data[2:0];
         end
         if (wr_en && wr_addr == ADDR_DMA_MASK && wr_strb[0]) begin
            dma_mask <= wr_data[7:0];
         end
         if (wr_en && wr_addr == ADDR_SWREQ && wr_strb[0]) begin
            swreq <= wr_data[7:0];
         end else if (term_ev && !next_valid[cur_ch]) begin
            swreq[cur_ch] <= 1'b0;
         end
         if (wr_en && wr_addr == ADDR_NEXT && wr_strb[0]) begin
            next_valid <= wr_data[7:0];
         end else if (term_ev) begin
            next_valid[cur_ch] <= 1'b0;
         end
         done <= (done & ~((wr_en && wr_addr == ADDR_EVENT && wr_strb[0]) ? wr_data[7:0] : 8'h00))
                 | (term_ev ? (8'h01 << cur_ch) : 8'h00);
      end
   end

   // AXI4-Lite write channel: address and data may arrive in either order
   assign wr_en  = aw_got && w_got && !s_axi_bvalid;
   assign wr_map = (wr_addr <= ADDR_LOG && wr_addr[1:0] == 2'h0 && wr_addr != ADDR_STATUS
                    && wr_addr != ADDR_LOG) || wr_addr[7:5] == COUNT_PAGE;

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         aw_got        <= 1'b0;
         w_got         <= 1'b0;
         wr_addr       <= '0;
         wr_data       <= 32'h0;
         wr_strb       <= 4'h0;
         s_axi_awready <= 1'b0;
         s_axi_wready  <= 1'b0;
         s_axi_bvalid  <= 1'b0;
         s_axi_bresp   <= RESP_OKAY;
      end else begin
         if (s_axi_awvalid && s_axi_awready) begin
            aw_got        <= 1'b1;
            wr_addr       <= {s_axi_awaddr[ADDR_W-1:2], 2'h0};
            s_axi_awready <= 1'b0;
         end else if (!aw_got && !s_axi_bvalid) begin
            s_axi_awready <= 1'b1;
         end
         if (s_axi_wvalid && s_axi_wready) begin
            w_got        <= 1'b1;
            wr_data      <= s_axi_wdata;
            wr_strb      <= s_axi_wstrb;
            s_axi_wready <= 1'b0;
         end else if (!w_got && !s_axi_bvalid) begin
            s_axi_wready <= 1'b1;
         end
         if (wr_en) begin
            s_axi_bvalid <= 1'b1;
            s_axi_bresp  <= wr_map ? RESP_OKAY : RESP_SLVERR;
            aw_got       <= 1'b0;
            w_got        <= 1'b0;
         end else if (s_axi_bvalid && s_axi_bready) begin
            s_axi_bvalid <= 1'b0;
         end
      end
   end

   // AXI4-Lite read channel; reading the log pops one entry
   assign log_pop = s_axi_arvalid && s_axi_arready
                    && {s_axi_araddr[ADDR_W-1:2], 2'h0} == ADDR_LOG;

   always_comb begin
      rd_map = 1'b1;
      rd_val = 32'h0;
      if (s_axi_araddr[7:5] == COUNT_PAGE) begin
         rd_val[CNT_W-1:0]  = count_q[s_axi_araddr[4:2]];
         rd_val[COUNT_ARMED] = armed[s_axi_araddr[4:2]];
      end else begin
         unique case ({s_axi_araddr[ADDR_W-1:2], 2'h0})
            ADDR_CTRL:     rd_val[2:0] = ctrl;
            ADDR_DMA_MASK: rd_val[7:0] = dma_mask;
            ADDR_SWREQ:    rd_val[7:0] = swreq;
            ADDR_NEXT:     rd_val[7:0] = next_valid;
            ADDR_STATUS: begin
               rd_val[STAT_BUSY]               = (state != ST_IDLE);
               rd_val[STAT_HOLD]               = hold_request;
               rd_val[STAT_CH_LSB +: 3]        = cur_ch;
               rd_val[STAT_LEVEL_LSB +: 5]     = log_level;
            end
            ADDR_EVENT: begin
               rd_val[7:0]            = done;
               rd_val[EVENT_IRQ_PEND] = irq_pend;
            end
            ADDR_LOG: begin
               rd_val[LOG_VALID]   = log_valid;
               rd_val[LOG_W-1:0]   = log_valid ? log_out : 8'h00;
            end
            default:       rd_map = 1'b0;
         endcase
      end
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         s_axi_arready <= 1'b0;
         s_axi_rvalid  <= 1'b0;
         s_axi_rdata   <= 32'h0;
         s_axi_rresp   <= RESP_OKAY;
      end else if (s_axi_arvalid && s_axi_arready) begin
         s_axi_arready <= 1'b0;
         s_axi_rvalid  <= 1'b1;
         s_axi_rdata   <= rd_val;
         s_axi_rresp   <= rd_map ? RESP_OKAY : RESP_SLVERR;
      end else if (s_axi_rvalid && s_axi_rready) begin
         s_axi_rvalid <= 1'b0;
      end else if (!s_axi_rvalid) begin
         s_axi_arready <= 1'b1;
      end
   end

endmodule : dmarq_top

`default_nettype wire

// ### design/dmarq_pkg.sv
/*
 * Package for the DMA request/acknowledge interface: register map, reset
 * values, access timing, state and carrier types.
 * Assumes a 50 MHz aclk and a 32-bit AXI4-Lite register bus.
 */
package dmarq_pkg;

   localparam int NUM_CH    = 8;
   localparam int CNT_W     = 16;
   localparam int ADDR_W    = 8;
   localparam int LOG_W     = 8;
   localparam int LOG_DEPTH = 16;

   // Register byte offsets
   localparam logic [7:0] ADDR_CTRL     = 8'h00;
   localparam logic [7:0] ADDR_DMA_MASK = 8'h04;
   localparam logic [7:0] ADDR_SWREQ    = 8'h08;
   localparam logic [7:0] ADDR_NEXT     = 8'h0C;
   localparam logic [7:0] ADDR_STATUS   = 8'h10;
   localparam logic [7:0] ADDR_EVENT    = 8'h14;
   localparam logic [7:0] ADDR_LOG      = 8'h18;
   localparam logic [2:0] COUNT_PAGE    = 3'h2;  // 0x40..0x5C, one per channel

   // Field positions
   localparam int CTRL_EOP_ASYNC = 0;
   localparam int CTRL_IRQ_EDGE  = 1;
   localparam int CTRL_IRQ_MASK  = 2;
   localparam int EVENT_IRQ_PEND = 8;
   localparam int COUNT_ARMED    = 16;
   localparam int STAT_BUSY      = 0;
   localparam int STAT_HOLD      = 1;
   localparam int STAT_CH_LSB    = 4;
   localparam int STAT_LEVEL_LSB = 8;
   localparam int LOG_VALID      = 31;

   // Reset values
   localparam logic [2:0] CTRL_RESET     = 3'h1;
   localparam logic [7:0] DMA_MASK_RESET = 8'hFF;

   localparam logic [2:0] ACK_IDLE = 3'h4;
   localparam logic [1:0] RESP_OKAY   = 2'h0;
   localparam logic [1:0] RESP_SLVERR = 2'h2;

   // Timing of one requester or target access
   localparam int CLK_PERIOD_NS = 20;
   localparam int ACCESS_NS     = 40;
   localparam int ACCESS_CYC    = (ACCESS_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

   typedef enum logic [1:0] {ST_IDLE, ST_HOLD, ST_REQ, ST_TGT} dmarq_state_type;

   typedef struct packed {
      logic irq_mask;
      logic irq_edge;
      logic eop_async;
   } dmarq_ctrl_type;

   typedef struct packed {
      logic [2:0] spare;
      logic       external;
      logic       reloaded;
      logic [2:0] chan;
   } dmarq_log_type;

   function automatic logic [31:0] dmarq_merge(input logic [31:0] old_v,
                                               input logic [31:0] new_v,
                                               input logic [3:0]  strb);
      logic [31:0] res;
      res = old_v;
      for (int i = 0; i < 4; i++) begin
         if (strb[i]) begin
            res[8*i +: 8] = new_v[8*i +: 8];
         end
      end
      return res;
   endfunction : dmarq_merge

endpackage : dmarq_pkg

// ### design/dmarq_sync.sv
/*
 * Two-stage synchroniser for a group of independent levels.
 * Assumes each bit is a slow level; no bus coherence across bits.
 */
`timescale 1ns/1ns
`default_nettype none

module dmarq_sync #(
   parameter int               WIDTH     = 1,
   parameter logic [WIDTH-1:0] RESET_VAL = '0
) (
   // Clock and reset
   input  wire logic             aclk,
   input  wire logic             aresetn,
   // Levels
   input  wire logic [WIDTH-1:0] d,
   output var  logic [WIDTH-1:0] q
);

   logic [WIDTH-1:0] stage1;

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         stage1 <= RESET_VAL;
         q      <= RESET_VAL;
      end else begin
         stage1 <= d;
         q      <= stage1;
      end
   end

endmodule : dmarq_sync

`default_nettype wire

// ### design/dmarq_fifo.sv
/*
 * Synchronous FIFO with valid/ready on both sides and a fill level.
 * Assumes DEPTH is a power of two.
 */
`timescale 1ns/1ns
`default_nettype none

module dmarq_fifo #(
   parameter int WIDTH = 8,
   parameter int DEPTH = 16,
   parameter int AW    = $clog2(DEPTH)
) (
   // Clock and reset
   input  wire logic          aclk,
   input  wire logic          aresetn,
   // Fill side
   input  wire logic          s_valid,
   output var  logic          s_ready,
   input  wire logic [WIDTH-1:0] s_data,
   // Drain side
   output var  logic          m_valid,
   input  wire logic          m_ready,
   output var  logic [WIDTH-1:0] m_data,
   output var  logic [AW:0]   level
);

   logic [WIDTH-1:0] mem [DEPTH];
   logic [AW:0]      wr_ptr;
   logic [AW:0]      rd_ptr;

   always_comb begin
      level   = wr_ptr - rd_ptr;
      s_ready = (level != (AW+1)'(DEPTH));
      m_valid = (level != '0);
      m_data  = mem[rd_ptr[AW-1:0]];
   end

   always_ff @(posedge aclk) begin
      if (s_valid && s_ready) begin
         mem[wr_ptr[AW-1:0]] <= s_data;
      end
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         wr_ptr <= '0;
         rd_ptr <= '0;
      end else begin
         if (s_valid && s_ready) begin
            wr_ptr <= wr_ptr + 1'b1;
         end
         if (m_valid && m_ready) begin
            rd_ptr <= rd_ptr + 1'b1;
         end
      end
   end

endmodule : dmarq_fifo

`default_nettype wire

// ### testbench/dmarq_monitor.sv
/* Concurrent checks on acknowledge, hold and end-of-process of dmarq_top.
   Bound from tb_top; sees only the top module's ports. */
`timescale 1ns/1ns
`default_nettype none
module dmarq_monitor
   import dmarq_pkg::*;
(
   // Clock and reset
   input wire logic       aclk,
   input wire logic       aresetn,
   // Watched ports
   input wire logic [2:0] encoded_channel_ack,
   input wire logic       hold_request,
   input wire logic       bus_grant_ack,
   input wire logic       end_of_process_line_oe_n
);
   wire logic [2:0] ack = encoded_channel_ack;
   default clocking cb @(posedge aclk); endclocking
   default disable iff (!aresetn);
   AST_ACK_GRANT:
      assert property (ack != ACK_IDLE |-> bus_grant_ack && hold_request) else $error("ack no grant");
   AST_ACK_NOHOLD:
      assert property (!hold_request |-> ack == ACK_IDLE) else $error("ack without hold");
   AST_ACK_STANDS:
      assert property ($changed(ack) && ack != ACK_IDLE |=> $stable(ack)) else $error("short ack");
   AST_ACK_TGT:
      assert property ($changed(ack) && ack == ACK_IDLE && hold_request |=> ack == ACK_IDLE)
         else $error("target access shows channel");
   AST_HOLD_WAIT:
      assert property (hold_request && !bus_grant_ack |=> ack == ACK_IDLE) else $error("early ack");
   AST_HOLD_FALL:
      assert property ($fell(hold_request) |-> ack == ACK_IDLE && $past(ack) == ACK_IDLE)
         else $error("hold dropped in access");
   AST_EOP_BUS:
      assert property (!end_of_process_line_oe_n |-> hold_request && bus_grant_ack)
         else $error("eop outside access");
   AST_EOP_LEN:
      assert property ($fell(end_of_process_line_oe_n) |=> !end_of_process_line_oe_n)
         else $error("eop too short");
endmodule : dmarq_monitor
`default_nettype wire

// ### testbench/dmarq_bus_master.sv
/* Bus master model: grants hold after a programmable lag.
   Assumes hold_request is a level from dmarq_top on aclk. */
`timescale 1ns/1ns
`default_nettype none
module dmarq_bus_master (
   // Clock and reset
   input wire logic       aclk,
   input wire logic       aresetn,
   // Hold handshake
   input wire logic       hold_request,
   input wire logic [3:0] lag,
   output var logic       bus_grant_ack
);
   logic [3:0] cnt;
   // Grant only after the bus is given up, dropped when hold falls
   always_ff @(posedge aclk) begin
      if (!aresetn || !hold_request) begin
         cnt <= 4'h0;
         bus_grant_ack <= 1'h0;
      end else if (cnt >= lag) begin
         bus_grant_ack <= 1'h1;
      end else begin
         cnt <= cnt + 4'h1;
      end
   end
endmodule : dmarq_bus_master
`default_nettype wire

// ### testbench/tb_top.sv
/* Self-checking bench for dmarq_top: registers, priority, acknowledge,
   end-of-process, channel 4 pin and interrupt 9. Needs the bus master model. */
`timescale 1ns/1ns
`default_nettype none
module tb_top import dmarq_pkg::*;;
   logic        aclk = 1'h0, aresetn = 1'h0, pin4 = 1'h1, ext_n = 1'h1;
   logic [7:0]  awaddr = 8'h0, araddr = 8'h0;
   logic [31:0] wdata = 32'h0;
   logic        awvalid = 1'h0, wvalid = 1'h0, bready = 1'h0, arvalid = 1'h0, rready = 1'h0;
   logic [6:0]  req = 7'h0;
   logic [3:0]  lag = 4'h0;
   wire logic   awready, wready, bvalid, arready, rvalid, eo_n, eoe_n, hold, grant, irq;
   wire logic [1:0]  bresp, rresp;
   wire logic [31:0] rdata;
   wire logic [2:0]  ack;
   wire logic        eop_n = ext_n & (eoe_n | eo_n); // Pull-up, wired with a peripheral
   int miscompares = 0, n_checks = 0;
   dmarq_top i_dut (.aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(awaddr),
      .s_axi_awvalid(awvalid), .s_axi_awready(awready), .s_axi_wdata(wdata),
      .s_axi_wstrb(4'hF), .s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_bresp(bresp),
      .s_axi_bvalid(bvalid), .s_axi_bready(bready), .s_axi_araddr(araddr),
      .s_axi_arvalid(arvalid), .s_axi_arready(arready), .s_axi_rdata(rdata),
      .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready),
      .channel_service_request(req), .shared_chan4_irq_pin(pin4),
      .end_of_process_line_in_n(eop_n), .end_of_process_line_out_n(eo_n),
      .end_of_process_line_oe_n(eoe_n), .encoded_channel_ack(ack), .hold_request(hold),
      .bus_grant_ack(grant), .shared_interrupt_input(irq));
   dmarq_bus_master i_bm (.aclk(aclk), .aresetn(aresetn), .hold_request(hold), .lag(lag),
      .bus_grant_ack(grant));
   always #10 aclk = ~aclk;
   task automatic check(input logic [31:0] got, input logic [31:0] exp);
      n_checks++;
      if (got !== exp) begin
         miscompares++;
         $display("ERROR %0t: got %h expected %h", $time, got, exp);
      end
   endtask : check
   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      @(posedge aclk);
      awaddr <= a;
      wdata <= d;
      awvalid <= 1'h1;
      wvalid <= 1'h1;
      bready <= 1'h1;
      do begin
         @(posedge aclk);
         if (awready) awvalid <= 1'h0;
         if (wready) wvalid <= 1'h0;
      end while (!bvalid);
      bready <= 1'h0;
      check(bresp, RESP_OKAY);
   endtask : wr
   task automatic rd(input logic [7:0] a, input logic [31:0] d, input logic [1:0] r);
      @(posedge aclk);
      araddr <= a;
      arvalid <= 1'h1;
      rready <= 1'h1;
      do begin
         @(posedge aclk);
         if (arready) arvalid <= 1'h0;
      end while (!rvalid);
      rready <= 1'h0;
      check(rdata, d);
      check(rresp, r);
   endtask : rd
   task automatic wait_ack(output logic [2:0] a, output logic e);
      repeat (60) begin
         @(posedge aclk);
         if (ack !== ACK_IDLE) break;
      end
      a = ack;
      e = eo_n;
   endtask : wait_ack
   task automatic t_prio;
      logic [2:0] a;
      logic       e;
      rd(ADDR_CTRL, 32'h1, RESP_OKAY);
      rd(ADDR_DMA_MASK, 32'hFF, RESP_OKAY);
      rd(8'h30, 32'h0, RESP_SLVERR);
      wr(ADDR_DMA_MASK, 32'h0);
      wr(8'h40, 32'h1);
      wr(8'h48, 32'h1);
      req <= 7'h05;
      wait_ack(a, e);
      check(a, 3'h0);
      check(e, 1'h0);
      while (ack !== ACK_IDLE) @(posedge aclk);
      wait_ack(a, e);
      check(a, 3'h2);
      req <= 7'h0;
      repeat (10) @(posedge aclk);
      check(hold, 1'h0);
      rd(ADDR_EVENT, 32'h5, RESP_OKAY);
      rd(ADDR_LOG, 32'h80000000, RESP_OKAY);
      rd(ADDR_LOG, 32'h80000002, RESP_OKAY);
   endtask : t_prio
   task automatic t_irq;
      pin4 <= 1'h0;
      repeat (5) @(posedge aclk);
      check(irq, 1'h1);
      pin4 <= 1'h1;
      repeat (5) @(posedge aclk);
      check(irq, 1'h0);
      wr(ADDR_EVENT, 32'h100);
      rd(ADDR_EVENT, 32'h5, RESP_OKAY);
      wr(ADDR_CTRL, 32'h3);
      pin4 <= 1'h0;
      repeat (3) @(posedge aclk);
      pin4 <= 1'h1;
      repeat (5) @(posedge aclk);
      check(irq, 1'h1);
      wr(ADDR_CTRL, 32'h7);
      repeat (3) @(posedge aclk);
      check(irq, 1'h0);
   endtask : t_irq
   task automatic t_chan4;
      logic h = 1'h0, e = 1'h1;
      lag <= 4'h5;
      wr(8'h50, 32'h1); // Pin left high requests channel 4
      repeat (40) begin
         @(posedge aclk);
         check(ack, ACK_IDLE);
         h = h | hold;
         e = e & eo_n;
      end
      check(h, 1'h1);
      check(e, 1'h0);
      rd(ADDR_LOG, 32'h80000004, RESP_OKAY);
   endtask : t_chan4
   task automatic t_eop;
      logic [2:0] a;
      logic       e;
      wr(ADDR_CTRL, 32'h4);
      wr(8'h44, 32'h5);
      wr(ADDR_NEXT, 32'h2);
      req <= 7'h02;
      wait_ack(a, e);
      check(a, 3'h1);
      check(e, 1'h1);
      ext_n <= 1'h0;
      req <= 7'h0;
      @(posedge aclk);
      ext_n <= 1'h1;
      repeat (8) @(posedge aclk);
      rd(8'h44, 32'h10005, RESP_OKAY);
      rd(ADDR_NEXT, 32'h0, RESP_OKAY);
      rd(ADDR_LOG, 32'h80000019, RESP_OKAY);
      wr(ADDR_DMA_MASK, 32'h10);
      wr(ADDR_SWREQ, 32'h10);
      wr(8'h50, 32'h1);
      repeat (20) @(posedge aclk);
      rd(ADDR_SWREQ, 32'h0, RESP_OKAY);
      rd(ADDR_LOG, 32'h80000004, RESP_OKAY);
   endtask : t_eop
   task automatic finish_test;
      $display("checks %0d mismatches %0d", n_checks, miscompares);
      if (miscompares == 0 && n_checks > 0) begin
         $display("RESULT: PASS");
      end else begin
         $display("RESULT: FAIL");
      end
      $finish;
   endtask : finish_test
   initial begin
      repeat (6) @(posedge aclk);
      aresetn <= 1'h1;
      t_prio;
      t_irq;
      t_chan4;
      t_eop;
      finish_test;
   end
   initial begin
      #100000;
      miscompares++;
      finish_test;
   end
endmodule : tb_top
bind dmarq_top dmarq_monitor i_mon (.aclk(aclk), .aresetn(aresetn),
   .encoded_channel_ack(encoded_channel_ack), .hold_request(hold_request),
   .bus_grant_ack(bus_grant_ack), .end_of_process_line_oe_n(end_of_process_line_oe_n));
`default_nettype wire
